/* File: common/gwp_cfg.svh */
// gwp_cfg.svh: sub-addresses, reset values and widths of the port wake, pull-up and
// alternate-select subregisters.
// assumes inclusion by bare name from package and design files.
`ifndef GWP_CFG_SVH
`define GWP_CFG_SVH

`define GWP_PORT_W 8
`define GWP_ADDR_W 8
`define GWP_SUB_ALTEN 8'h02
`define GWP_SUB_WAKE 8'h05
`define GWP_SUB_PULLUP 8'h06
`define GWP_SUB_ALTSEL1 8'h07
`define GWP_RESET_VAL 8'h00
`define GWP_ALTEN_RESET_D 8'h01
`define GWP_RESET_PIN_BIT 0
`define GWP_ADDR_RESET 8'h00
`define GWP_ARM_CYCLES 3'h5

`endif

/* File: common/gwp_pkg.sv */
// gwp_pkg.sv: types shared by the port subregister block.
// assumes gwp_cfg.svh on the include path.
`default_nettype none
`include "gwp_cfg.svh"

package gwp_pkg;
	typedef logic [`GWP_PORT_W-1:0] gwp_byte_type;
	typedef logic [`GWP_ADDR_W-1:0] gwp_sub_type;
	// which subregister the control-register access lands on
	typedef enum logic [2:0] {
		GWP_SEL_NONE = 3'b000,
		GWP_SEL_ALTEN = 3'b001,
		GWP_SEL_WAKE = 3'b010,
		GWP_SEL_PULLUP = 3'b011,
		GWP_SEL_ALTSEL1 = 3'b100
	} gwp_sel_type;
endpackage

`default_nettype wire

/* File: hw/gwp_sync.sv */
// gwp_sync.sv: three-flop pin synchroniser with agreement filter, one lane per pin.
// assumes pins are asynchronous to clk_i.
`default_nettype none
`include "gwp_cfg.svh"

module gwp_sync #(
	parameter int WIDTH = `GWP_PORT_W
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] level_o
);
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] level;
	logic [WIDTH-1:0] next_level;

	////////////////////////////////////////////////////////////////////////////////
	// filtered level moves only when stages two and three agree
	always_comb begin
		for (int n = 0; n < WIDTH; n++) begin
			next_level[n] = (stage2[n] == stage3[n]) ? stage3[n] : level[n];
		end
	end

	// first flop feeds only the second
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta <= '0;
			stage2 <= '0;
			stage3 <= '0;
			level <= '0;
		end else begin
			meta <= pin_i;
			stage2 <= meta;
			stage3 <= stage2;
			level <= next_level;
		end
	end

	assign level_o = level;
endmodule

`default_nettype wire

/* File: hw/gwp_port.sv */
// gwp_port.sv: one 8-bit port's wake enable, pull-up enable and alternate set-1
// subregisters, reached through the port address and port control registers.
// assumes a simple strobe register port from the cpu and an alternate-function core
// that supplies two candidate functions per pin.
`default_nettype none
`include "gwp_cfg.svh"

module gwp_port
	import gwp_pkg::*;
#(
	parameter int WIDTH = `GWP_PORT_W,
	parameter bit IS_PORT_D = 1'b0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic addr_wr_i,
	input wire logic ctl_wr_i,
	input wire gwp_pkg::gwp_byte_type wdata_i,
	output logic [WIDTH-1:0] addr_rdata_o,
	output logic [WIDTH-1:0] ctl_rdata_o,
	input wire logic stop_mode_i,
	output logic wake_o,
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] pullup_en_o,
	input wire logic [WIDTH-1:0] gpio_out_i,
	input wire logic [WIDTH-1:0] gpio_oe_i,
	input wire logic [WIDTH-1:0] alt0_out_i,
	input wire logic [WIDTH-1:0] alt0_oe_i,
	input wire logic [WIDTH-1:0] alt1_out_i,
	input wire logic [WIDTH-1:0] alt1_oe_i,
	output logic [WIDTH-1:0] pin_o,
	output logic [WIDTH-1:0] pin_oe_o
);
	import gwp_pkg::*;

	gwp_sub_type sub_addr;
	logic [WIDTH-1:0] port_altfunc_enable;
	logic [WIDTH-1:0] port_stop_wake_enable;
	logic [WIDTH-1:0] port_pullup_enable;
	logic [WIDTH-1:0] port_altfunc_select_one;
	gwp_sub_type next_sub_addr;
	logic [WIDTH-1:0] next_altfunc_enable;
	logic [WIDTH-1:0] next_stop_wake_enable;
	logic [WIDTH-1:0] next_pullup_enable;
	logic [WIDTH-1:0] next_altfunc_select_one;
	logic [WIDTH-1:0] pin_level;
	logic [WIDTH-1:0] pin_prev;
	logic [WIDTH-1:0] wake_mask;
	logic [WIDTH-1:0] pin_edge;
	logic wake;
	logic next_wake;
	logic [WIDTH-1:0] ctl_rdata;
	logic [WIDTH-1:0] next_ctl_rdata;
	gwp_sel_type sel;
	logic [2:0] arm_count;
	logic [2:0] next_arm_count;
	logic armed;

	// sub-address decode, shared by write and read paths
	function automatic gwp_sel_type decode_sub(input gwp_sub_type a);
		case (a)
			`GWP_SUB_ALTEN: decode_sub = GWP_SEL_ALTEN;
			`GWP_SUB_WAKE: decode_sub = GWP_SEL_WAKE;
			`GWP_SUB_PULLUP: decode_sub = GWP_SEL_PULLUP;
			`GWP_SUB_ALTSEL1: decode_sub = GWP_SEL_ALTSEL1;
			default: decode_sub = GWP_SEL_NONE;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// address latch: picks the subregister for the following control accesses
	always_comb begin
		next_sub_addr = addr_wr_i ? wdata_i : sub_addr;
	end

	// the latch is readable back through addr_rdata_o
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sub_addr <= `GWP_ADDR_RESET;
		end else begin
			sub_addr <= next_sub_addr;
		end
	end

	// subregisters: only a control write to a mapped sub-address changes one
	always_comb begin
		sel = decode_sub(sub_addr);
		next_altfunc_enable = port_altfunc_enable;
		next_stop_wake_enable = port_stop_wake_enable;
		next_pullup_enable = port_pullup_enable;
		next_altfunc_select_one = port_altfunc_select_one;
		if (ctl_wr_i) begin
			case (sel)
				GWP_SEL_ALTEN: next_altfunc_enable = wdata_i;
				GWP_SEL_WAKE: next_stop_wake_enable = wdata_i;
				GWP_SEL_PULLUP: next_pullup_enable = wdata_i;
				GWP_SEL_ALTSEL1: next_altfunc_select_one = wdata_i;
				default: ;
			endcase
		end
	end

	// reset leaves port D's reset-pin bit on its alternate function
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			port_altfunc_enable <= IS_PORT_D ? `GWP_ALTEN_RESET_D : `GWP_RESET_VAL;
			port_stop_wake_enable <= `GWP_RESET_VAL;
			port_pullup_enable <= `GWP_RESET_VAL;
			port_altfunc_select_one <= `GWP_RESET_VAL;
		end else begin
			port_altfunc_enable <= next_altfunc_enable;
			port_stop_wake_enable <= next_stop_wake_enable;
			port_pullup_enable <= next_pullup_enable;
			port_altfunc_select_one <= next_altfunc_select_one;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// control read: follows the next values so a write reads back one cycle later
	always_comb begin
		case (sel)
			GWP_SEL_ALTEN: next_ctl_rdata = next_altfunc_enable;
			GWP_SEL_WAKE: next_ctl_rdata = next_stop_wake_enable;
			GWP_SEL_PULLUP: next_ctl_rdata = next_pullup_enable;
			GWP_SEL_ALTSEL1: next_ctl_rdata = next_altfunc_select_one;
			default: next_ctl_rdata = '0; // unknown sub-addresses read zero
		endcase
		// an address write blanks the read for the cycle in which the selection moves
		if (addr_wr_i) begin
			next_ctl_rdata = '0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctl_rdata <= '0;
		end else begin
			ctl_rdata <= next_ctl_rdata;
		end
	end

	assign addr_rdata_o = sub_addr;
	assign ctl_rdata_o = ctl_rdata;

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers, then edge detection for stop-mode wake
	gwp_sync #(
		.WIDTH(WIDTH)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(pin_i),
		.level_o(pin_level)
	);

	// wake edges are ignored until sync stages and prev hold real pin levels;
	// otherwise a pin idling high would fake an edge just after reset
	always_comb begin
		armed = (arm_count == `GWP_ARM_CYCLES);
		next_arm_count = armed ? arm_count : 3'(arm_count + 3'h1);
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			arm_count <= 3'h0;
		end else begin
			arm_count <= next_arm_count;
		end
	end

	// reset pin shares port D bit 0, so it is masked out of wake sources
	always_comb begin
		wake_mask = port_stop_wake_enable;
		if (IS_PORT_D) begin
			wake_mask[`GWP_RESET_PIN_BIT] = 1'b0;
		end
		pin_edge = (pin_level ^ pin_prev) & wake_mask;
		next_wake = armed & stop_mode_i & (|pin_edge);
	end

	// prev tracks continuously so a stale level never fakes an edge on stop entry
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_prev <= '0;
			wake <= 1'b0;
		end else begin
			pin_prev <= pin_level;
			wake <= next_wake;
		end
	end

	assign wake_o = wake;

	////////////////////////////////////////////////////////////////////////////////
	// pad control: pull-ups and alternate-function mux, per pin
	assign pullup_en_o = port_pullup_enable;

	// select alone never takes the pin; the enable must be set too
	generate
		for (genvar n = 0; n < WIDTH; n++) begin : g_pin
			logic alt_out;
			logic alt_oe;
			assign alt_out = port_altfunc_select_one[n] ? alt1_out_i[n] : alt0_out_i[n];
			assign alt_oe = port_altfunc_select_one[n] ? alt1_oe_i[n] : alt0_oe_i[n];
			assign pin_o[n] = port_altfunc_enable[n] ? alt_out : gpio_out_i[n];
			assign pin_oe_o[n] = port_altfunc_enable[n] ? alt_oe : gpio_oe_i[n];
		end
	endgenerate
endmodule

`default_nettype wire

/* File: testbench/gwp_port_assertions.sv */
// checker: port timing of the subregister block
// assumes bind to gwp_port, strobes one clock wide
`default_nettype none
module gwp_port_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic addr_wr_i,
	input wire logic ctl_wr_i,
	input wire gwp_pkg::gwp_byte_type wdata_i,
	input wire logic [7:0] addr_rdata_o,
	input wire logic [7:0] ctl_rdata_o,
	input wire logic stop_mode_i,
	input wire logic wake_o,
	input wire logic [7:0] pin_i,
	input wire logic [7:0] pullup_en_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import gwp_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// a control write to sub reads back, and shows on its outputs, one cycle later
	property p_wr(sub, v);
		ctl_wr_i && !addr_wr_i && addr_rdata_o == sub |=> v == $past(wdata_i);
	endproperty
	a_addr_latch: assert property (addr_wr_i |=> addr_rdata_o == $past(wdata_i))
		else $error("addr latch");
	a_wake_route: assert property (p_wr(8'h05, ctl_rdata_o)) else $error("wake read");
	a_pull_route: assert property (p_wr(8'h06, ctl_rdata_o)) else $error("pull read");
	a_sel_route: assert property (p_wr(8'h07, ctl_rdata_o)) else $error("sel read");
	a_pull_pin: assert property (p_wr(8'h06, pullup_en_o)) else $error("pull out");
	a_reset_clear: assert property ($past(rst_i) |-> !wake_o && ctl_rdata_o == 8'h00
		&& pullup_en_o == 8'h00) else $error("not clear");
	// wake only out of stop, and never from pins that sat still
	a_wake_stop: assert property (wake_o |-> $past(stop_mode_i)) else $error("wake");
	a_wake_quiet: assert property ($stable(pin_i)[*8] |-> !wake_o) else $error("idle");
	a_unmapped_zero: assert property ((!addr_wr_i && !(addr_rdata_o inside
		{8'h02, 8'h05, 8'h06, 8'h07}))[*3] |-> ctl_rdata_o == 8'h00) else $error("unmapped");
	c_wake: cover property (stop_mode_i && wake_o);
	c_sel: cover property (ctl_wr_i && addr_rdata_o == 8'h07);
	c_unmapped: cover property (addr_rdata_o == 8'h10);
endmodule
////////////////////////////////////////
bind gwp_port gwp_port_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .addr_wr_i(addr_wr_i),
	.ctl_wr_i(ctl_wr_i), .wdata_i(wdata_i), .addr_rdata_o(addr_rdata_o),
	.ctl_rdata_o(ctl_rdata_o), .stop_mode_i(stop_mode_i), .wake_o(wake_o),
	.pin_i(pin_i), .pullup_en_o(pullup_en_o));
`default_nettype wire

/* File: testbench/gwp_pin_model.sv */
// external circuitry on the eight port pins
// assumes the block's pad drive wins over the outside driver
`default_nettype none
module gwp_pin_model (
	input wire logic [7:0] ext_v_i,
	input wire logic [7:0] ext_en_i,
	input wire logic [7:0] pu_i,
	input wire logic [7:0] out_i,
	input wire logic [7:0] oe_i,
	output logic [7:0] lvl_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// floating pins go to the pull-up, else the inverse of the last drive
	assign lvl_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_v_i)
		| (~oe_i & ~ext_en_i & (pu_i | ~ext_v_i));
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// directed register and pin tests of one port (port D flavour)
// assumes checker and pin model compiled before
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import gwp_pkg::*;
	logic clk_i, rst_i, addr_wr_i, ctl_wr_i, stop_mode_i, wake_o;
	gwp_byte_type wdata_i;
	logic [7:0] addr_rdata_o, ctl_rdata_o, pin_i, pullup_en_o, pin_o, pin_oe_o;
	logic [7:0] ext_v, ext_en, g_o, g_e, a0_o, a0_e, a1_o, a1_e;
	logic [7:0] subs [3] = '{8'h05, 8'h06, 8'h07};
	logic [7:0] vals [3] = '{8'ha5, 8'h3c, 8'h96};
	int mismatches = 0;
	int checks_done = 0;
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	gwp_port #(.WIDTH(8), .IS_PORT_D(1'b1)) dut (.clk_i(clk_i), .rst_i(rst_i),
		.addr_wr_i(addr_wr_i), .ctl_wr_i(ctl_wr_i), .wdata_i(wdata_i),
		.addr_rdata_o(addr_rdata_o), .ctl_rdata_o(ctl_rdata_o), .stop_mode_i(stop_mode_i),
		.wake_o(wake_o), .pin_i(pin_i), .pullup_en_o(pullup_en_o), .gpio_out_i(g_o),
		.gpio_oe_i(g_e), .alt0_out_i(a0_o), .alt0_oe_i(a0_e), .alt1_out_i(a1_o),
		.alt1_oe_i(a1_e), .pin_o(pin_o), .pin_oe_o(pin_oe_o));
	gwp_pin_model pins (.ext_v_i(ext_v), .ext_en_i(ext_en), .pu_i(pullup_en_o),
		.out_i(pin_o), .oe_i(pin_oe_o), .lvl_o(pin_i));
	////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// strobe raised on one edge, dropped on the edge that takes it; next call leaves a gap
	task automatic strobe(input logic a, input logic [7:0] d);
		@(posedge clk_i);
		addr_wr_i <= a;
		ctl_wr_i <= !a;
		wdata_i <= d;
		@(posedge clk_i);
		addr_wr_i <= 1'b0;
		ctl_wr_i <= 1'b0;
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		strobe(1'b1, a);
		strobe(1'b0, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		strobe(1'b1, a);
		chk(addr_rdata_o, a);
		repeat (3) @(posedge clk_i);
		#1 chk(ctl_rdata_o, exp);
	endtask
	// flip pins from outside and watch a bounded window for a wake pulse
	task automatic wake_win(input logic [7:0] flip, input logic exp);
		logic seen;
		seen = 1'b0;
		@(posedge clk_i);
		ext_v <= ext_v ^ flip;
		repeat (12) begin
			@(posedge clk_i);
			#1 seen = seen | wake_o;
		end
		chk({7'h0, seen}, {7'h0, exp});
	endtask
	task automatic summarize();
		$display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// main sequence: reset, routing, pad mux, wake
	initial begin
		{rst_i, addr_wr_i, ctl_wr_i, stop_mode_i, wdata_i} = 12'h800;
		{ext_v, ext_en} = 16'h00ff;
		{g_o, g_e, a0_o, a0_e, a1_o, a1_e} = 48'h112233445566;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		#1;
		foreach (subs[i]) rd(subs[i], 8'h00);
		rd(8'h02, 8'h01);
		foreach (subs[i]) wr(subs[i], vals[i]);
		foreach (subs[i]) rd(subs[i], vals[i]);
		rd(8'h10, 8'h00);
		chk(pullup_en_o, 8'h3c);
		wr(8'h02, 8'hf0);
		chk(pin_o, 8'hf0 & (8'h96 & a1_o | ~8'h96 & a0_o) | ~8'hf0 & g_o);
		chk(pin_oe_o, 8'hf0 & (8'h96 & a1_e | ~8'h96 & a0_e) | ~8'hf0 & g_e);
		@(posedge clk_i);
		{g_e, a0_e, a1_e} <= 24'h0;
		wr(8'h05, 8'h0f);
		@(posedge clk_i);
		stop_mode_i <= 1'b1;
		wake_win(8'h01, 1'b0);
		wake_win(8'h10, 1'b0);
		wake_win(8'h04, 1'b1);
		wake_win(8'h04, 1'b1);
		@(posedge clk_i);
		stop_mode_i <= 1'b0;
		wake_win(8'h08, 1'b0);
		// second reset in mid-run must clear the wake, pull-up and alternate set-1 writes
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		#1;
		foreach (subs[i]) rd(subs[i], 8'h00);
		chk(pullup_en_o, 8'h00);
		summarize();
	end
endmodule
`default_nettype wire
